// ===== design/mlds_pkg.sv
package mlds_pkg;
    // Clock and scan timing
    localparam int unsigned CLK_PERIOD_NS  = 100;
    localparam int unsigned SCAN_PERIOD_NS = 500000;
    localparam int unsigned SCAN_CYCLES    = SCAN_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned DIV_W          = 16;

    // Digit and segment geometry
    localparam int unsigned NUM_DIGITS = 6;
    localparam int unsigned BCD_W      = 4;
    localparam int unsigned SEG_W      = 7;
    localparam int unsigned DEC_OUTS   = 10;

    // Scan counter moduli and decoder limit
    localparam logic [3:0] NORMAL_MOD = 4'h6;
    localparam logic [3:0] DIM_MOD    = 4'hC;
    localparam logic [3:0] DEC_LAST   = 4'h9;

    // Segment patterns, active low, order g f e d c b a
    localparam logic [6:0] SEG_ALL_OFF = 7'h7F;
    localparam logic [6:0] SEG_ALL_ON  = 7'h00;

    // Register word addresses
    localparam logic [1:0] ADDR_CTRL   = 2'h0;
    localparam logic [1:0] ADDR_STATUS = 2'h1;
    localparam logic [1:0] ADDR_DIGITS = 2'h2;

    // Control field positions and reset value
    localparam int unsigned CTRL_DIM   = 0;
    localparam int unsigned CTRL_RBI_N = 1;
    localparam int unsigned CTRL_BI_N  = 2;
    localparam int unsigned CTRL_LT_N  = 3;
    localparam logic [3:0]  CTRL_RESET = 4'hE;

    // Status field positions
    localparam int unsigned STAT_COUNT = 0;
    localparam int unsigned STAT_ANODE = 4;
    localparam int unsigned STAT_BCD   = 10;

    typedef struct packed {
        logic [DIV_W-1:0]      div_cnt;
        logic                  scan_tick;
        logic [3:0]            scan_count;
        logic [3:0]            ctrl;
        logic [NUM_DIGITS-1:0] anode_n;
        logic [SEG_W-1:0]      seg_n;
        logic [BCD_W-1:0]      bcd_sel;
        logic                  ack;
        logic [31:0]           rdata;
    } mlds_state_t;

    localparam mlds_state_t ST_RESET = '{
        div_cnt:    '0,
        scan_tick:  1'b0,
        scan_count: '0,
        ctrl:       CTRL_RESET,
        anode_n:    '1,
        seg_n:      SEG_ALL_OFF,
        bcd_sel:    '0,
        ack:        1'b0,
        rdata:      '0
    };
endpackage

// ===== design/mlds_seg_if.sv
interface mlds_seg_if;
    logic [3:0] bcd;
    logic       rbi_n;
    logic       bi_n;
    logic       lt_n;
    logic [6:0] seg_n;

    modport dec (
        input  bcd,
        input  rbi_n,
        input  bi_n,
        input  lt_n,
        output seg_n
    );
    modport drv (
        output bcd,
        output rbi_n,
        output bi_n,
        output lt_n,
        input  seg_n
    );
endinterface

// ===== design/mlds_seg_dec.sv
module mlds_seg_dec (
    mlds_seg_if.dec seg_if
);
    // BCD to seven segments, low means segment sinks current
    function automatic logic [6:0] seg_map(input logic [3:0] v);
        case (v)
            4'h0: seg_map = 7'h40;
            4'h1: seg_map = 7'h79;
            4'h2: seg_map = 7'h24;
            4'h3: seg_map = 7'h30;
            4'h4: seg_map = 7'h19;
            4'h5: seg_map = 7'h12;
            4'h6: seg_map = 7'h02; // Six with its tail
            4'h7: seg_map = 7'h78;
            4'h8: seg_map = 7'h00;
            4'h9: seg_map = 7'h10; // Nine with its tail
            4'hA: seg_map = 7'h27;
            4'hB: seg_map = 7'h33;
            4'hC: seg_map = 7'h1D;
            4'hD: seg_map = 7'h16;
            4'hE: seg_map = 7'h07;
            default: seg_map = mlds_pkg::SEG_ALL_OFF;
        endcase
    endfunction

    // Blank beats lamp test, lamp test beats ripple blank
    always_comb begin
        if (!seg_if.bi_n) begin
            seg_if.seg_n = mlds_pkg::SEG_ALL_OFF;
        end else if (!seg_if.lt_n) begin
            seg_if.seg_n = mlds_pkg::SEG_ALL_ON;
        end else if (!seg_if.rbi_n && seg_if.bcd == 4'h0) begin
            seg_if.seg_n = mlds_pkg::SEG_ALL_OFF;
        end else begin
            seg_if.seg_n = seg_map(seg_if.bcd);
        end
    end
endmodule

// ===== design/mlds_scanner.sv
module mlds_scanner #(
    parameter int unsigned SCAN_DIV_CYCLES = mlds_pkg::SCAN_CYCLES
) (
    input  wire logic        clk_sys_in,
    input  wire logic        reset_in,
    input  wire logic [23:0] digits_bcd_in,
    input  wire logic [1:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    output logic      [5:0]  digit_select_line_n_out,
    output logic      [6:0]  seg_n_out
);
    localparam int unsigned ND = mlds_pkg::NUM_DIGITS;
    localparam int unsigned BW = mlds_pkg::BCD_W;
    localparam logic [mlds_pkg::DIV_W-1:0] DIV_LAST =
        mlds_pkg::DIV_W'(SCAN_DIV_CYCLES - 1);

    // Count to ten active-low one-hot lines, all high above nine
    function automatic logic [9:0] dec10(input logic [3:0] c);
        logic [9:0] o;
        o = '1;
        if (c <= mlds_pkg::DEC_LAST) begin
            o[c] = 1'b0;
        end
        return o;
    endfunction

    mlds_pkg::mlds_state_t st_ff;
    mlds_pkg::mlds_state_t nxt_st;

    logic [9:0]    dec_n;
    logic [ND-1:0] sel_n;
    logic [ND-1:0] sel_hi;
    logic [BW-1:0] gated [ND];
    logic [BW-1:0] four_way;
    logic [BW-1:0] two_way;
    logic [BW-1:0] mux_bcd;
    logic [3:0]    count_inc;
    logic          dimmer_select;
    logic          bus_req;

    mlds_seg_if seg_if ();

    // Scan count decode: low lines drive anodes, inverted copy steers mux
    assign dec_n  = dec10(st_ff.scan_count);
    assign sel_n  = dec_n[ND-1:0];
    assign sel_hi = ~sel_n;

    // Gate every digit with its select
    for (genvar d = 0; d < ND; d++) begin : g_gate
        assign gated[d] = digits_bcd_in[d*BW +: BW] & {BW{sel_hi[d]}};
    end

    // Six-way selector from four-way and two-way AND-OR groups
    assign four_way = gated[0] | gated[1] | gated[2] | gated[3];
    assign two_way  = gated[4] | gated[5];
    assign mux_bcd  = four_way | two_way;

    // Single shared segment decoder
    assign seg_if.bcd   = mux_bcd;
    assign seg_if.rbi_n = st_ff.ctrl[mlds_pkg::CTRL_RBI_N];
    assign seg_if.bi_n  = st_ff.ctrl[mlds_pkg::CTRL_BI_N];
    assign seg_if.lt_n  = st_ff.ctrl[mlds_pkg::CTRL_LT_N];

    mlds_seg_dec u_dec (
        .seg_if (seg_if.dec)
    );

    assign dimmer_select       = st_ff.ctrl[mlds_pkg::CTRL_DIM];
    assign count_inc = st_ff.scan_count + 4'h1;
    assign bus_req   = avs_read_in | avs_write_in;

    // Next state of divider, scan counter, drivers and bus slave
    always_comb begin
        nxt_st = st_ff;

        // 2 kHz scan tick from the clock divider
        if (st_ff.div_cnt == DIV_LAST) begin
            nxt_st.div_cnt   = '0;
            nxt_st.scan_tick = 1'b1;
        end else begin
            nxt_st.div_cnt   = st_ff.div_cnt + mlds_pkg::DIV_W'(1);
            nxt_st.scan_tick = 1'b0;
        end

        // Scan counter, modulo 6 or 12
        if (!dimmer_select && st_ff.scan_count >= mlds_pkg::NORMAL_MOD) begin
            nxt_st.scan_count = 4'h0;
        end else if (st_ff.scan_tick) begin
            if (!dimmer_select && count_inc >= mlds_pkg::NORMAL_MOD) begin
                nxt_st.scan_count = 4'h0;
            end else if (count_inc >= mlds_pkg::DIM_MOD) begin
                nxt_st.scan_count = 4'h0;
            end else begin
                nxt_st.scan_count = count_inc;
            end
        end

        // Anodes and segments registered together, so they stay in step
        nxt_st.anode_n = sel_n;
        nxt_st.seg_n   = seg_if.seg_n;
        nxt_st.bcd_sel = mux_bcd;

        // One wait cycle per bus request
        nxt_st.ack = bus_req & ~st_ff.ack;

        // Control write takes effect when waitrequest is low
        if (avs_write_in && st_ff.ack && avs_address_in == mlds_pkg::ADDR_CTRL
            && avs_byteenable_in[0]) begin
            nxt_st.ctrl = avs_writedata_in[3:0];
        end

        // Read data captured during the wait cycle
        if (avs_read_in && !st_ff.ack) begin
            nxt_st.rdata = '0;
            case (avs_address_in)
                mlds_pkg::ADDR_CTRL: begin
                    nxt_st.rdata[3:0] = st_ff.ctrl;
                end
                mlds_pkg::ADDR_STATUS: begin
                    nxt_st.rdata[mlds_pkg::STAT_COUNT +: 4]  = st_ff.scan_count;
                    nxt_st.rdata[mlds_pkg::STAT_ANODE +: ND] = ~st_ff.anode_n;
                    nxt_st.rdata[mlds_pkg::STAT_BCD +: BW]   = st_ff.bcd_sel;
                end
                mlds_pkg::ADDR_DIGITS: begin
                    nxt_st.rdata[23:0] = digits_bcd_in;
                end
                default: begin
                    nxt_st.rdata = '0;
                end
            endcase
        end
    end

    // State register, synchronous reset
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            st_ff <= mlds_pkg::ST_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs
    assign avs_waitrequest_out     = bus_req & ~st_ff.ack;
    assign avs_readdata_out        = st_ff.rdata;
    assign digit_select_line_n_out = st_ff.anode_n;
    assign seg_n_out               = st_ff.seg_n;

    // Checks on scan sequencing, display drive and control register writes
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);

    sequence s_tick_at5;
        st_ff.scan_tick && !dimmer_select && st_ff.scan_count == 4'h5;
    endsequence

    sequence s_back_to_zero;
        st_ff.scan_count == 4'h0 ##1 st_ff.scan_count == 4'h0;
    endsequence

    property p_mod6_wrap;
        s_tick_at5 |=> st_ff.scan_count == 4'h0;
    endproperty
    a_mod6_wrap: assert property (p_mod6_wrap)
        else $error("scan count did not wrap after five");

    property p_six_clears;
        !dimmer_select && st_ff.scan_count >= 4'h6 |=> st_ff.scan_count == 4'h0;
    endproperty
    a_six_clears: assert property (p_six_clears)
        else $error("count at six not cleared at once");

    property p_step;
        st_ff.scan_tick && st_ff.scan_count < 4'h5
            |=> st_ff.scan_count == $past(st_ff.scan_count) + 4'h1;
    endproperty
    a_step: assert property (p_step)
        else $error("scan count did not step by one");

    property p_hold;
        !st_ff.scan_tick && (dimmer_select || st_ff.scan_count < 4'h6)
            |=> $stable(st_ff.scan_count);
    endproperty
    a_hold: assert property (p_hold)
        else $error("scan count moved without a tick");

    property p_dim_run;
        st_ff.scan_tick && dimmer_select && st_ff.scan_count == 4'h5 ##1 dimmer_select
            |-> st_ff.scan_count == 4'h6;
    endproperty
    a_dim_run: assert property (p_dim_run)
        else $error("dimmed count was cleared at six");

    property p_dim_wrap;
        st_ff.scan_tick && dimmer_select && st_ff.scan_count == 4'hB |=> s_back_to_zero;
    endproperty
    a_dim_wrap: assert property (p_dim_wrap)
        else $error("dimmed count did not wrap after eleven");

    property p_anode;
        1'b1 |=> st_ff.anode_n == $past(sel_n) && st_ff.seg_n == $past(seg_if.seg_n);
    endproperty
    a_anode: assert property (p_anode)
        else $error("anode drive out of step with the scan");

    property p_one_digit;
        $onehot0(~st_ff.anode_n);
    endproperty
    a_one_digit: assert property (p_one_digit)
        else $error("more than one digit lit");

    property p_dim_dark;
        dimmer_select && st_ff.scan_count >= 4'h6 |=> &st_ff.anode_n;
    endproperty
    a_dim_dark: assert property (p_dim_dark)
        else $error("digit lit in a dark dimmed slot");

    property p_mux;
        st_ff.scan_count < 4'h6 |-> mux_bcd == digits_bcd_in[st_ff.scan_count*BW +: BW];
    endproperty
    a_mux: assert property (p_mux)
        else $error("mux does not carry the selected digit");

    property p_blank;
        !seg_if.bi_n |=> st_ff.seg_n == mlds_pkg::SEG_ALL_OFF;
    endproperty
    a_blank: assert property (p_blank)
        else $error("blank input did not blank segments");

    property p_lamp;
        seg_if.bi_n && !seg_if.lt_n |=> st_ff.seg_n == mlds_pkg::SEG_ALL_ON;
    endproperty
    a_lamp: assert property (p_lamp)
        else $error("lamp test did not light all segments");

    property p_rbi;
        seg_if.bi_n && seg_if.lt_n && !seg_if.rbi_n && mux_bcd == 4'h0
            |=> st_ff.seg_n == mlds_pkg::SEG_ALL_OFF;
    endproperty
    a_rbi: assert property (p_rbi)
        else $error("leading zero not blanked");

    property p_ctrl_write;
        avs_write_in && !avs_waitrequest_out && avs_address_in == mlds_pkg::ADDR_CTRL
            && avs_byteenable_in[0] |=> st_ff.ctrl == $past(avs_writedata_in[3:0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("control write not stored");
endmodule

// ===== bench/mlds_led_model.sv
module mlds_led_model (
    input  wire logic       clk_in,
    input  wire logic       clr_in,
    input  wire logic [5:0] anode_n_in,
    output int              lit_cnt_out [7],
    output logic            order_bad_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] last_ff;

    // Lit time per digit, dark time, scan order watch
    always_ff @(posedge clk_in) begin
        if (clr_in) begin
            lit_cnt_out   <= '{default: 0};
            order_bad_out <= 1'b0;
            last_ff       <= 3'h7;
        end else if (anode_n_in == 6'h3F) begin
            lit_cnt_out[6] <= lit_cnt_out[6] + 1;
        end else if ($countones(~anode_n_in) != 1) begin
            order_bad_out <= 1'b1;
        end else begin
            for (int d = 0; d < 6; d++) begin
                if (!anode_n_in[d]) begin
                    lit_cnt_out[d] <= lit_cnt_out[d] + 1;
                    if (last_ff != 3'h7 && last_ff != 3'(d) && 3'(d) != ((last_ff == 3'h5) ? 3'h0 : last_ff + 3'h1))
                        order_bad_out <= 1'b1;
                    last_ff <= 3'(d);
                end
            end
        end
    end
endmodule

// ===== bench/mlds_scanner_tb.sv
module mlds_scanner_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DIV = 8;
    logic        clk_sys_in;
    logic        reset_in;
    logic        rd_en;
    logic        wr_en;
    logic        clr;
    logic        wait_req;
    logic        order_bad;
    logic [23:0] digits;
    logic [1:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] got;
    logic [3:0]  be;
    logic [5:0]  anode_n;
    logic [6:0]  seg_n;
    int          lit_cnt [7];
    int          miscompares;
    int          comparisons;
    logic [6:0]  seg_tbl [16] = '{7'h40, 7'h79, 7'h24, 7'h30, 7'h19, 7'h12, 7'h02, 7'h78,
                                 7'h00, 7'h10, 7'h27, 7'h33, 7'h1D, 7'h16, 7'h07, 7'h7F};
    logic [3:0]  ctl_tbl [5]  = '{4'hC, 4'hC, 4'hA, 4'h6, 4'h2};
    logic [6:0]  ctl_exp [5]  = '{7'h7F, 7'h79, 7'h7F, 7'h00, 7'h7F};

    mlds_scanner #(.SCAN_DIV_CYCLES(DIV)) dut_u (
        .clk_sys_in(clk_sys_in), .reset_in(reset_in), .digits_bcd_in(digits),
        .avs_address_in(addr), .avs_read_in(rd_en), .avs_write_in(wr_en),
        .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wait_req), .digit_select_line_n_out(anode_n), .seg_n_out(seg_n));

    mlds_led_model led_u (.clk_in(clk_sys_in), .clr_in(clr), .anode_n_in(anode_n),
                          .lit_cnt_out(lit_cnt), .order_bad_out(order_bad));

    // Clock, 100 ns period
    initial begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end

    task automatic report_and_stop();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic timed_out();
        miscompares++;
        $display("unexpected at %0t: wait ran out", $time);
        report_and_stop();
    endtask

    task automatic chk_vec(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask

    task automatic chk_cnt(input int g, input int e);
        comparisons++;
        if (g != e) begin
            miscompares++;
            $display("unexpected at %0t: count %0d want %0d", $time, g, e);
        end
    endtask

    // One bus cycle, held until waitrequest is sampled low
    task automatic avs(input logic w, input logic [1:0] a, input logic [31:0] wd,
                       input logic [3:0] b, output logic [31:0] rd);
        int n;
        @(posedge clk_sys_in);
        addr  <= a;
        wdata <= wd;
        be    <= b;
        wr_en <= w;
        rd_en <= ~w;
        n = 0;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        if (wait_req !== 1'b0) timed_out();
        rd = rdata;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
    endtask

    task automatic wait_slot(input int s);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end while (anode_n !== 6'(~(6'h01 << s)) && n < 1000);
        if (n >= 1000) timed_out();
    endtask

    task automatic run_counts(input logic [3:0] ctl, input int slots);
        avs(1'b1, mlds_pkg::ADDR_CTRL, {28'h0, ctl}, 4'hF, got);
        repeat (12 * DIV) @(posedge clk_sys_in);
        clr <= 1'b1;
        @(posedge clk_sys_in);
        clr <= 1'b0;
        repeat (2 * slots * DIV) @(posedge clk_sys_in);
        #1;
        for (int d = 0; d < 6; d++)
            chk_cnt(lit_cnt[d], 2 * DIV);
        chk_cnt(lit_cnt[6], 2 * (slots - 6) * DIV);
        chk_vec({31'h0, order_bad}, 32'h0);
        $display("test scan with control %h done", ctl);
    endtask

    // Watchdog
    initial begin
        repeat (100000) @(posedge clk_sys_in);
        timed_out();
    end

    // Main sequence
    initial begin
        reset_in = 1'b1;
        rd_en = 1'b0;
        wr_en = 1'b0;
        clr = 1'b1;
        addr = 2'h0;
        wdata = 32'h0;
        be = 4'hF;
        digits = 24'h543210;
        miscompares = 0;
        comparisons = 0;
        repeat (2) @(posedge clk_sys_in);
        #1;
        chk_vec({26'h0, anode_n}, 32'h3F);
        chk_vec({25'h0, seg_n}, 32'h7F);
        @(posedge clk_sys_in);
        reset_in <= 1'b0;
        clr <= 1'b0;
        avs(1'b0, mlds_pkg::ADDR_CTRL, 32'h0, 4'hF, got);
        chk_vec(got, {28'h0, mlds_pkg::CTRL_RESET});
        avs(1'b0, mlds_pkg::ADDR_DIGITS, 32'h0, 4'hF, got);
        chk_vec(got, 32'h543210);
        avs(1'b1, 2'h3, 32'hFFFF_FFFF, 4'hF, got);
        avs(1'b0, 2'h3, 32'h0, 4'hF, got);
        chk_vec(got, 32'h0);
        $display("test registers done");
        // One code per row in its own slot, other digits blank
        for (int v = 0; v < 16; v++) begin
            @(posedge clk_sys_in);
            digits <= (24'hFFFFFF & ~(24'hF << (4 * (v % 6)))) | (24'(v) << (4 * (v % 6)));
            wait_slot(v % 6);
            chk_vec({25'h0, seg_n}, {25'h0, seg_tbl[v]});
        end
        $display("test decode rows done");
        run_counts(4'hE, 6);
        run_counts(4'hF, 12);
        run_counts(4'hE, 6);
        // Blank, lamp test and ripple blank
        @(posedge clk_sys_in);
        digits <= 24'h000010;
        for (int i = 0; i < 5; i++) begin
            avs(1'b1, mlds_pkg::ADDR_CTRL, {28'h0, ctl_tbl[i]}, 4'hF, got);
            repeat (2) @(posedge clk_sys_in);
            wait_slot((i == 0) ? 0 : 1);
            chk_vec({25'h0, seg_n}, {25'h0, ctl_exp[i]});
        end
        avs(1'b1, mlds_pkg::ADDR_CTRL, 32'hF, 4'hE, got);
        avs(1'b0, mlds_pkg::ADDR_CTRL, 32'h0, 4'hF, got);
        chk_vec(got, 32'h2);
        // Status: count in normal range, exactly one digit lit
        avs(1'b0, mlds_pkg::ADDR_STATUS, 32'h0, 4'hF, got);
        chk_vec({31'h0, got[3:0] < 4'h6}, 32'h1);
        chk_vec({31'h0, $onehot(got[9:4])}, 32'h1);
        $display("test controls done");
        report_and_stop();
    end
endmodule
